/* bench/acrts_host_model.sv */
// host model that reads the status map through the index ports
module acrts_host_model (
	input  wire logic        clock_in,
	input  wire logic [15:0] status_word_in,
	input  wire logic        discrete_bit_in,
	output logic      [1:0]  status_index_out,
	output logic      [5:0]  discrete_index_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// index lines start at the first register and point
	initial
	begin
		status_index_out = 2'h0;
		discrete_index_out = 6'h00;
	end

	// host register numbers start at 30001 for device register zero
	task automatic read_word(input int host_reg, output logic [15:0] word);
		@(negedge clock_in);
		status_index_out = 2'(host_reg - 30001);
		@(negedge clock_in);
		word = status_word_in;
	endtask

	// host point numbers start at 10001 for device point zero
	task automatic read_point(input int host_pt, output logic bit_val);
		@(negedge clock_in);
		discrete_index_out = 6'(host_pt - 10001);
		@(negedge clock_in);
		bit_val = discrete_bit_in;
	endtask
endmodule

/* bench/actuator_relay_timer_status_bench.sv */
// self-checking bench for the relay, timer and status block
module actuator_relay_timer_status_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// one status row: pin values beside the words they should give
	typedef struct packed {
		logic [15:0] live;
		logic        stall;
		logic        fail;
		logic [1:0]  net;
		logic [2:0]  ana;
		logic        sesd;
		logic        setup;
		logic [15:0] std_w;
		logic [15:0] ext_w;
		logic [15:0] mdl_w;
	} acrts_row_t;

	logic        clock_in;
	logic        reset_n_in;
	logic [15:0] live;
	logic        stall, fail, sesd, setup, power, host, oreq, creq;
	logic [1:0]  net;
	logic [2:0]  ana;
	logic [7:0]  mode, val;
	logic [6:0]  pos;
	logic [1:0]  sidx;
	logic [5:0]  didx;
	logic        relay, trip_a, trip_b, open_m, close_m, dbit, b;
	logic [15:0] sword, w;
	logic [15:0] e [4];
	acrts_row_t  rows [6];
	int          miscompares, checked, cycles, i, p;

	acrts_top #(.TICK_CYCLES(10)) dut_u (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.live_inputs_in(live), .stall_alarm_in(stall),
		.actuator_fail_in(fail), .network_alarm_in(net),
		.analog_fault_in(ana), .software_esd_in(sesd),
		.setup_mode_in(setup), .power_ok_in(power),
		.mode_switch_bank_in(mode), .value_switch_bank_in(val),
		.valve_position_in(pos), .open_request_in(oreq),
		.close_request_in(creq), .host_relay_in(host),
		.status_index_in(sidx), .discrete_index_in(didx),
		.relay_coil_out(relay), .trip_a_reached_out(trip_a),
		.trip_b_reached_out(trip_b), .open_motor_out(open_m),
		.close_motor_out(close_m), .status_word_out(sword),
		.discrete_bit_out(dbit)
	);

	acrts_host_model host_u (
		.clock_in(clock_in), .status_word_in(sword),
		.discrete_bit_in(dbit), .status_index_out(sidx),
		.discrete_index_out(didx)
	);

	// clock and hang guard
	always #50 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// let pins pass the synchronisers
	task automatic settle();
		repeat (8) @(negedge clock_in);
	endtask

	// load one setting through the switch banks
	task automatic cfg(input logic [7:0] m, input logic [7:0] v);
		setup = 1'h1;
		mode = m;
		val = v;
		settle();
		setup = 1'h0;
		settle();
		mode = 8'h00;
	endtask

	function automatic logic mot(input logic cl);
		return cl ? close_m : open_m;
	endfunction

	// measure one full off and on phase of a pulsing motor output
	task automatic duty(input logic cl, input int on_c, input int off_c);
		int n, lo, hi;
		n = 0;
		lo = 0;
		hi = 0;
		while (mot(cl) !== 1'h1 && n < 300)
		begin
			@(negedge clock_in);
			n++;
		end
		while (mot(cl) === 1'h1 && n < 600)
		begin
			@(negedge clock_in);
			n++;
		end
		while (mot(cl) === 1'h0 && n < 900)
		begin
			@(negedge clock_in);
			n++;
			lo++;
		end
		while (mot(cl) === 1'h1 && n < 1200)
		begin
			@(negedge clock_in);
			n++;
			hi++;
		end
		check("motor_off_cycles", 16'(lo), 16'(off_c));
		check("motor_on_cycles", 16'(hi), 16'(on_c));
	endtask

	// motor must follow its request without any gap
	task automatic steady(input logic cl);
		int lo;
		lo = 0;
		settle();
		repeat (60)
		begin
			@(negedge clock_in);
			if (mot(cl) !== 1'h1)
				lo++;
		end
		check("motor_gaps", 16'(lo), 16'h0000);
	endtask

	// main sequence
	initial
	begin
		{clock_in, reset_n_in, live, stall, fail, sesd, setup} = '0;
		{net, ana, mode, val, pos, oreq, creq} = '0;
		power = 1'h1;
		host = 1'h1;
		rows = '{
			'{16'h0000, 1'h0, 1'h0, 2'h0, 3'h0, 1'h0, 1'h0,
				16'h0000, 16'h0004, 16'h0000},
			'{16'h0021, 1'h0, 1'h0, 2'h0, 3'h0, 1'h0, 1'h0,
				16'h0021, 16'h0001, 16'h0000},
			'{16'h0058, 1'h0, 1'h0, 2'h0, 3'h0, 1'h0, 1'h0,
				16'h8058, 16'h10d0, 16'h0000},
			'{16'h7f80, 1'h0, 1'h0, 2'h0, 3'h0, 1'h0, 1'h0,
				16'h9e80, 16'he384, 16'h0000},
			'{16'h0000, 1'h1, 1'h1, 2'h3, 3'h7, 1'h1, 1'h1,
				16'ha100, 16'h0ca4, 16'h001f},
			'{16'h0000, 1'h0, 1'h1, 2'h1, 3'h2, 1'h0, 1'h0,
				16'ha000, 16'h0484, 16'h0004}};
		repeat (12) @(negedge clock_in);
		check("outputs_in_reset", {relay, trip_a, trip_b, open_m, close_m,
			dbit, sword[9:0]}, 16'h0000);
		reset_n_in = 1'h1;
		$display("test reset done");
		// status map rows, every word and every point
		for (i = 0; i < 6; i++)
		begin
			{live, stall, fail, net, ana, sesd, setup} = rows[i][72:48];
			e = '{rows[i].live, rows[i].std_w, rows[i].ext_w, rows[i].mdl_w};
			settle();
			for (p = 0; p < 4; p++)
			begin
				host_u.read_word(30001 + p, w);
				check("status_word", w, e[p]);
			end
			for (p = 0; p < 64; p++)
			begin
				host_u.read_point(10001 + p, b);
				check("discrete_bit", 16'(b),
					16'(e[p/16][p%16]));
			end
		end
		{live, stall, fail, net, ana, sesd, setup} = '0;
		$display("test status rows done");
		// every relay function code in two pin states
		for (i = 0; i < 9; i++)
		begin
			cfg(acrts_pkg::MODE_RELAY_ONE, 8'(i));
			live = 16'h0010;
			host = 1'h1;
			sesd = 1'h0;
			settle();
			check("relay_coil", 16'(relay),
				16'((9'h0a5 >> i) & 9'h001));
			live = 16'h0020;
			host = 1'h0;
			sesd = 1'h1;
			settle();
			check("relay_coil", 16'(relay),
				16'((9'h052 >> i) & 9'h001));
		end
		sesd = 1'h0;
		cfg(acrts_pkg::MODE_RELAY_ONE, acrts_pkg::RLY_NO_HOST);
		host = 1'h1;
		power = 1'h0;
		settle();
		check("relay_power_lost", {15'h0, relay}, 16'h0000);
		power = 1'h1;
		settle();
		check("relay_power_back", {15'h0, relay}, 16'h0001);
		$display("test relay done");
		// trip point A at the top of the range and disabled, trip point B at 60
		cfg(acrts_pkg::MODE_TRIP_A, 8'h64);
		cfg(acrts_pkg::MODE_RELAY_ONE, acrts_pkg::RLY_NO_TRIP_A);
		pos = 7'h63;
		settle();
		check("trip_a_below", {14'h0, trip_a, relay}, 16'h0000);
		pos = 7'h64;
		settle();
		check("trip_a_reached", {14'h0, trip_a, relay}, 16'h0003);
		cfg(acrts_pkg::MODE_TRIP_A, 8'h00);
		pos = 7'h00;
		settle();
		check("trip_a_off", {14'h0, trip_a, relay}, 16'h0000);
		cfg(acrts_pkg::MODE_TRIP_B, 8'h3c);
		pos = 7'h3b;
		settle();
		check("trip_b_below", {14'h0, trip_a, trip_b}, 16'h0000);
		pos = 7'h3c;
		settle();
		check("trip_b_reached", {14'h0, trip_a, trip_b}, 16'h0001);
		$display("test trip points done");
		// opening duty timers, selector and starter gating
		cfg(acrts_pkg::MODE_STARTER, 8'h01);
		cfg(acrts_pkg::MODE_OPEN_ON, 8'h02);
		cfg(acrts_pkg::MODE_OPEN_OFF, 8'h03);
		live = 16'h0020;
		oreq = 1'h1;
		duty(1'h0, 20, 30);
		live = 16'h0010;
		steady(1'h0);
		live = 16'h0020;
		cfg(acrts_pkg::MODE_STARTER, 8'h00);
		steady(1'h0);
		cfg(acrts_pkg::MODE_STARTER, 8'h01);
		cfg(acrts_pkg::MODE_OPEN_ON, 8'h00);
		steady(1'h0);
		oreq = 1'h0;
		$display("test opening duty done");
		// water hammer pulsing against closing timers
		cfg(acrts_pkg::MODE_STARTER, 8'h00);
		cfg(acrts_pkg::MODE_WATER_HAM, 8'h28);
		cfg(acrts_pkg::MODE_CLOSE_ON, 8'h03);
		cfg(acrts_pkg::MODE_CLOSE_OFF, 8'h04);
		pos = 7'h28;
		creq = 1'h1;
		duty(1'h1, 20, 20);
		cfg(acrts_pkg::MODE_STARTER, 8'h01);
		duty(1'h1, 10, 10);
		pos = 7'h32;
		duty(1'h1, 30, 40);
		$display("test closing duty done");
		// reset in mid run: outputs drop, water hammer and relay settings back to default
		reset_n_in = 1'h0;
		@(negedge clock_in);
		check("outputs_mid_reset", {relay, trip_a, trip_b, open_m,
			close_m, dbit, sword[9:0]}, 16'h0000);
		pos = 7'h00;
		reset_n_in = 1'h1;
		steady(1'h1);
		check("relay_default", 16'(relay), 16'h0001);
		creq = 1'h0;
		$display("test mid reset done");
		end_of_test();
	end
endmodule

/* rtl/acrts_cfg_store.sv */
// setting store loaded from the value switch bank in setup mode
module acrts_cfg_store (
	input  wire logic                              clock_in,
	input  wire logic                              reset_n_in,
	input  wire logic                              setup_in,
	input  wire logic [7:0]                        mode_in,
	input  wire logic [7:0]                        value_in,
	output logic [acrts_pkg::CFG_SLOTS*8-1:0]      cfg_out
);
	localparam logic [7:0] SLOT_CODE [acrts_pkg::CFG_SLOTS] = '{
		acrts_pkg::MODE_RELAY_ONE, acrts_pkg::MODE_STARTER,
		acrts_pkg::MODE_TRIP_A,    acrts_pkg::MODE_TRIP_B,
		acrts_pkg::MODE_WATER_HAM, acrts_pkg::MODE_OPEN_ON,
		acrts_pkg::MODE_OPEN_OFF,  acrts_pkg::MODE_CLOSE_ON,
		acrts_pkg::MODE_CLOSE_OFF};

	// one slot per setting, written while its mode code is selected
	genvar g;
	generate
		for (g = 0; g < acrts_pkg::CFG_SLOTS; g++)
		begin : slot
			logic [7:0] value;
			logic [7:0] next_value;
			always_comb
			begin
				next_value = value;
				if (setup_in && mode_in == SLOT_CODE[g])
					next_value = value_in;
			end
			always_ff @(posedge clock_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
					value <= acrts_pkg::CFG_RESET;
				else
					value <= next_value;
			end
			assign cfg_out[g*8 +: 8] = value;
		end
	endgenerate
endmodule

/* rtl/acrts_pkg.sv */
// shared constants for the actuator relay, timer and status block
package acrts_pkg;
	// setup mode codes on the mode switch bank (S1 is bit 0)
	localparam logic [7:0] MODE_RELAY_ONE  = 8'h16; // S2,S3,S5
	localparam logic [7:0] MODE_STARTER    = 8'h07; // S1,S2,S3
	localparam logic [7:0] MODE_TRIP_A     = 8'h18; // S4,S5
	localparam logic [7:0] MODE_TRIP_B     = 8'h12; // S2,S5
	localparam logic [7:0] MODE_WATER_HAM  = 8'h1a; // S2,S4,S5
	localparam logic [7:0] MODE_OPEN_ON    = 8'h1d; // S1,S3,S4,S5
	localparam logic [7:0] MODE_OPEN_OFF   = 8'h1e; // S2,S3,S4,S5
	localparam logic [7:0] MODE_CLOSE_ON   = 8'h1b; // S1,S2,S4,S5
	localparam logic [7:0] MODE_CLOSE_OFF  = 8'h1c; // S3,S4,S5

	// setting store slots
	localparam int CFG_SLOTS = 9;
	localparam int SLOT_RELAY     = 0;
	localparam int SLOT_STARTER   = 1;
	localparam int SLOT_TRIP_A    = 2;
	localparam int SLOT_TRIP_B    = 3;
	localparam int SLOT_WATER_HAM = 4;
	localparam int SLOT_OPEN_ON   = 5;
	localparam int SLOT_OPEN_OFF  = 6;
	localparam int SLOT_CLOSE_ON  = 7;
	localparam int SLOT_CLOSE_OFF = 8;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// relay function codes on the value switch bank
	localparam logic [7:0] RLY_NO_HOST   = 8'h00;
	localparam logic [7:0] RLY_NO_REMOTE = 8'h01;
	localparam logic [7:0] RLY_NO_LOCAL  = 8'h02;
	localparam logic [7:0] RLY_NO_TRIP_A = 8'h03;
	localparam logic [7:0] RLY_NO_ESD    = 8'h04;
	localparam logic [7:0] RLY_NC_HOST   = 8'h05;
	localparam logic [7:0] RLY_NC_REMOTE = 8'h06;
	localparam logic [7:0] RLY_NC_LOCAL  = 8'h07;
	localparam logic [7:0] RLY_NC_TRIP_A = 8'h08;

	// motor starter codes
	localparam logic [7:0] STARTER_ELECTROMECH = 8'h00;

	// input register indices
	localparam logic [1:0] IREG_LIVE     = 2'h0;
	localparam logic [1:0] IREG_STANDARD = 2'h1;
	localparam logic [1:0] IREG_EXTENDED = 2'h2;
	localparam logic [1:0] IREG_MODEL    = 2'h3;

	// live input bit positions
	localparam int LV_OPEN_LIMIT   = 0;
	localparam int LV_CLOSE_LIMIT  = 1;
	localparam int LV_AUX_OPEN     = 2;
	localparam int LV_AUX_CLOSE    = 3;
	localparam int LV_LOCAL        = 4;
	localparam int LV_REMOTE       = 5;
	localparam int LV_OPEN_TORQUE  = 6;
	localparam int LV_CLOSE_TORQUE = 7;
	localparam int LV_POWER_MON    = 8;
	localparam int LV_THERMAL      = 9;
	localparam int LV_PHASE        = 10;
	localparam int LV_LOCAL_ESD    = 11;

	// widths of the synchronised pin group
	localparam int SYNC_W = 42;

	// timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SECOND_NS       = 1000000000;
	localparam int TICK_CYCLES     = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [7:0] AWH_SEC_FAST = 8'h01; // solid-state / drive
	localparam logic [7:0] AWH_SEC_SLOW = 8'h02; // electromechanical

	// duty cycle states
	typedef enum logic [2:0] {
		DC_PASS = 3'b001,
		DC_ON   = 3'b010,
		DC_OFF  = 3'b100
	} acrts_duty_t;
endpackage

/* rtl/acrts_top.sv */
// actuator user relay, travel duty-cycle timers and status words
// Overview of operation
// - make-contact relay: off host, S1 remote, S2 local, S1S2 trip A, S3 EMERGENCY_SHUTDOWN
// - break-contact relay: S1S3 host, S2S3 remote, S1S2S3 local, S4 trip A; coil driven the same as the make-contact codes, not inverted
// - relay drive drops whenever actuator power is lost; nothing latches
// - mode S4,5 sets trip point A in percent; zero disables it
// - mode S2,5 sets trip point B in percent; zero disables it
// - mode S2,4,5 sets water hammer start position on closing; zero off
// - mode S1,3,4,5 sets opening on time in seconds; zero disables
// - mode S2,3,4,5 sets opening off time in seconds; zero disables
// - mode S1,2,4,5 sets closing on time in seconds; zero disables
// - mode S3,4,5 sets closing off time in seconds; zero disables
// - duty timers run only with the selector in remote
// - duty timers apply only with solid-state or variable speed starter
// - water hammer pulses 50 percent, 1 s fast starters, 2 s others
// - active water hammer pulsing overrides closing duty timers
// - all status points are numbered from zero; host adds one
// - four input registers hold live, standard, extended, model words
// - model word: setup, three analog faults, software EMERGENCY_SHUTDOWN, rest zero
// - discrete points 0-15 mirror the live hardware inputs
// - point 30 reads zero, point 31 ORs the alarms above
// - extended group reports mid travel stop, ORed alarm, network alarms
module acrts_top #(
	parameter int TICK_CYCLES = acrts_pkg::TICK_CYCLES
) (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic [15:0] live_inputs_in,
	input  wire logic        stall_alarm_in,
	input  wire logic        actuator_fail_in,
	input  wire logic [1:0]  network_alarm_in,
	input  wire logic [2:0]  analog_fault_in,
	input  wire logic        software_esd_in,
	input  wire logic        setup_mode_in,
	input  wire logic        power_ok_in,
	input  wire logic [7:0]  mode_switch_bank_in,
	input  wire logic [7:0]  value_switch_bank_in,
	input  wire logic [6:0]  valve_position_in,
	input  wire logic        open_request_in,
	input  wire logic        close_request_in,
	input  wire logic        host_relay_in,
	input  wire logic [1:0]  status_index_in,
	input  wire logic [5:0]  discrete_index_in,
	output logic             relay_coil_out,
	output logic             trip_a_reached_out,
	output logic             trip_b_reached_out,
	output logic             open_motor_out,
	output logic             close_motor_out,
	output logic [15:0]      status_word_out,
	output logic             discrete_bit_out
);
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

	// pin synchroniser: three stages, change taken when stages 2 and 3 agree
	logic [acrts_pkg::SYNC_W-1:0] raw, s1, s2, s3, pins;
	logic [acrts_pkg::SYNC_W-1:0] next_pins;
	assign raw = {live_inputs_in, stall_alarm_in, actuator_fail_in,
		network_alarm_in, analog_fault_in, software_esd_in,
		setup_mode_in, power_ok_in, mode_switch_bank_in,
		value_switch_bank_in};
	always_comb
	begin
		// per bit, so one restless pin cannot hold back the others
		next_pins = (s3 & ~(s2 ^ s3)) | (pins & (s2 ^ s3));
	end
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			pins <= '0;
		end
		else
		begin
			s1   <= raw;
			s2   <= s1;
			s3   <= s2;
			pins <= next_pins;
		end
	end

	logic [15:0] live;
	logic        stall, fail, setup, soft_esd, power_ok;
	logic [1:0]  net_alarm;
	logic [2:0]  ain_fault;
	logic [7:0]  mode_bank, value_bank;
	assign {live, stall, fail, net_alarm, ain_fault, soft_esd, setup,
		power_ok, mode_bank, value_bank} = pins;

	// setting store
	logic [acrts_pkg::CFG_SLOTS*8-1:0] cfg;
	acrts_cfg_store u_cfg (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.setup_in   (setup),
		.mode_in    (mode_bank),
		.value_in   (value_bank),
		.cfg_out    (cfg)
	);
	logic [7:0] relay_fn, starter, trip_a, trip_b, awh_pos;
	logic [7:0] open_on, open_off, close_on, close_off;
	assign relay_fn  = cfg[acrts_pkg::SLOT_RELAY*8 +: 8];
	assign starter   = cfg[acrts_pkg::SLOT_STARTER*8 +: 8];
	assign trip_a    = cfg[acrts_pkg::SLOT_TRIP_A*8 +: 8];
	assign trip_b    = cfg[acrts_pkg::SLOT_TRIP_B*8 +: 8];
	assign awh_pos   = cfg[acrts_pkg::SLOT_WATER_HAM*8 +: 8];
	assign open_on   = cfg[acrts_pkg::SLOT_OPEN_ON*8 +: 8];
	assign open_off  = cfg[acrts_pkg::SLOT_OPEN_OFF*8 +: 8];
	assign close_on  = cfg[acrts_pkg::SLOT_CLOSE_ON*8 +: 8];
	assign close_off = cfg[acrts_pkg::SLOT_CLOSE_OFF*8 +: 8];

	logic local_sel, remote_sel, any_esd, hit_a, hit_b;
	assign local_sel  = live[acrts_pkg::LV_LOCAL];
	assign remote_sel = live[acrts_pkg::LV_REMOTE];
	assign any_esd    = live[acrts_pkg::LV_LOCAL_ESD] | soft_esd;
	// trip points count only when configured non-zero
	assign hit_a = (trip_a != 8'h00) && ({1'b0, valve_position_in} >= trip_a);
	assign hit_b = (trip_b != 8'h00) && ({1'b0, valve_position_in} >= trip_b);

	// relay coil decode
	logic next_relay, next_hit_a, next_hit_b;
	always_comb
	begin
		case (relay_fn)
			acrts_pkg::RLY_NO_HOST:   next_relay = host_relay_in;
			acrts_pkg::RLY_NO_REMOTE: next_relay = remote_sel;
			acrts_pkg::RLY_NO_LOCAL:  next_relay = local_sel;
			acrts_pkg::RLY_NO_TRIP_A: next_relay = hit_a;
			acrts_pkg::RLY_NO_ESD:    next_relay = any_esd;
			acrts_pkg::RLY_NC_HOST:   next_relay = host_relay_in;
			acrts_pkg::RLY_NC_REMOTE: next_relay = remote_sel;
			acrts_pkg::RLY_NC_LOCAL:  next_relay = local_sel;
			acrts_pkg::RLY_NC_TRIP_A: next_relay = hit_a;
			default:                  next_relay = 1'b0;
		endcase
		next_relay = next_relay & power_ok;
		next_hit_a = hit_a;
		next_hit_b = hit_b;
	end
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			relay_coil_out     <= 1'b0;
			trip_a_reached_out <= 1'b0;
			trip_b_reached_out <= 1'b0;
		end
		else
		begin
			relay_coil_out     <= next_relay;
			trip_a_reached_out <= next_hit_a;
			trip_b_reached_out <= next_hit_b;
		end
	end

	// choose on/off seconds: water hammer first, then duty timers
	logic       awh_active, duty_ok;
	logic [7:0] t_on, t_off, awh_sec;
	always_comb
	begin
		awh_active = close_request_in && (awh_pos != 8'h00) &&
			({1'b0, valve_position_in} <= awh_pos);
		duty_ok = remote_sel &&
			(starter != acrts_pkg::STARTER_ELECTROMECH);
		awh_sec = (starter == acrts_pkg::STARTER_ELECTROMECH) ?
			acrts_pkg::AWH_SEC_SLOW : acrts_pkg::AWH_SEC_FAST;
		t_on  = 8'h00;
		t_off = 8'h00;
		if (awh_active)
		begin
			t_on  = awh_sec;
			t_off = awh_sec;
		end
		else if (close_request_in && duty_ok)
		begin
			t_on  = close_on;
			t_off = close_off;
		end
		else if (open_request_in && duty_ok)
		begin
			t_on  = open_on;
			t_off = open_off;
		end
	end

	// duty cycle sequencer with one-second tick
	acrts_pkg::acrts_duty_t state, next_state;
	logic [23:0] tick_cnt, next_tick_cnt;
	logic [7:0]  sec_left, next_sec_left;
	logic        pulse, tick, next_open, next_close;
	always_comb
	begin
		pulse         = (t_on != 8'h00) && (t_off != 8'h00);
		tick          = (tick_cnt == TICK_LAST);
		next_state    = state;
		next_sec_left = sec_left;
		next_tick_cnt = tick ? 24'h000000 : tick_cnt + 24'h000001;
		case (state)
			acrts_pkg::DC_PASS:
			begin
				next_tick_cnt = 24'h000000;
				if (pulse)
				begin
					next_state    = acrts_pkg::DC_ON;
					next_sec_left = t_on;
				end
			end
			acrts_pkg::DC_ON:
			begin
				if (!pulse)
					next_state = acrts_pkg::DC_PASS;
				else if (tick && sec_left <= 8'h01)
				begin
					next_state    = acrts_pkg::DC_OFF;
					next_sec_left = t_off;
				end
				else if (tick)
					next_sec_left = sec_left - 8'h01;
			end
			acrts_pkg::DC_OFF:
			begin
				if (!pulse)
					next_state = acrts_pkg::DC_PASS;
				else if (tick && sec_left <= 8'h01)
				begin
					next_state    = acrts_pkg::DC_ON;
					next_sec_left = t_on;
				end
				else if (tick)
					next_sec_left = sec_left - 8'h01;
			end
			default:
				next_state = acrts_pkg::DC_PASS;
		endcase
		if (!pulse)
			next_tick_cnt = 24'h000000;
		// motor held off during the off phase only
		next_open  = open_request_in && (state != acrts_pkg::DC_OFF);
		next_close = close_request_in && (state != acrts_pkg::DC_OFF);
	end
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state           <= acrts_pkg::DC_PASS;
			tick_cnt        <= 24'h000000;
			sec_left        <= 8'h00;
			open_motor_out  <= 1'b0;
			close_motor_out <= 1'b0;
		end
		else
		begin
			state           <= next_state;
			tick_cnt        <= next_tick_cnt;
			sec_left        <= next_sec_left;
			open_motor_out  <= next_open;
			close_motor_out <= next_close;
		end
	end

	// status words, numbered from zero
	logic [15:0] w_live, w_std, w_ext, w_model;
	logic        opening, closing, unit_alarm;
	logic [63:0] points;
	logic [15:0] next_word;
	logic        next_bit;
	always_comb
	begin
		opening    = live[acrts_pkg::LV_AUX_OPEN];
		closing    = live[acrts_pkg::LV_AUX_CLOSE];
		unit_alarm = live[acrts_pkg::LV_OPEN_TORQUE] |
			live[acrts_pkg::LV_CLOSE_TORQUE] | stall |
			live[acrts_pkg::LV_POWER_MON] | live[acrts_pkg::LV_THERMAL] |
			live[acrts_pkg::LV_PHASE] | live[acrts_pkg::LV_LOCAL_ESD] | fail;
		w_live = live;
		w_std = {unit_alarm, 1'b0, fail,
			live[acrts_pkg::LV_LOCAL_ESD], live[acrts_pkg::LV_PHASE],
			live[acrts_pkg::LV_THERMAL], live[acrts_pkg::LV_POWER_MON],
			stall, live[acrts_pkg::LV_CLOSE_TORQUE],
			live[acrts_pkg::LV_OPEN_TORQUE], remote_sel, local_sel,
			closing, opening, live[acrts_pkg::LV_CLOSE_LIMIT],
			live[acrts_pkg::LV_OPEN_LIMIT]};
		w_ext = {live[acrts_pkg::LV_PHASE], live[acrts_pkg::LV_LOCAL_ESD],
			live[acrts_pkg::LV_CLOSE_TORQUE],
			live[acrts_pkg::LV_OPEN_TORQUE], net_alarm[1], net_alarm[0],
			live[acrts_pkg::LV_POWER_MON], live[acrts_pkg::LV_THERMAL],
			unit_alarm, local_sel, stall, closing, opening,
			~(live[acrts_pkg::LV_OPEN_LIMIT] |
			live[acrts_pkg::LV_CLOSE_LIMIT] | opening | closing),
			live[acrts_pkg::LV_CLOSE_LIMIT],
			live[acrts_pkg::LV_OPEN_LIMIT]};
		w_model = {11'h000, soft_esd, ain_fault, setup};
		points  = {w_model, w_ext, w_std, w_live};
		case (status_index_in)
			acrts_pkg::IREG_LIVE:     next_word = w_live;
			acrts_pkg::IREG_STANDARD: next_word = w_std;
			acrts_pkg::IREG_EXTENDED: next_word = w_ext;
			acrts_pkg::IREG_MODEL:    next_word = w_model;
			default:                  next_word = 16'h0000;
		endcase
		next_bit = points[discrete_index_in];
	end
	always_ff @(posedge clock_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			status_word_out  <= 16'h0000;
			discrete_bit_out <= 1'b0;
		end
		else
		begin
			status_word_out  <= next_word;
			discrete_bit_out <= next_bit;
		end
	end

	// checks
	sequence s_off_phase;
		state == acrts_pkg::DC_OFF;
	endsequence
	a_relay_power_drop: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		!power_ok |=> !relay_coil_out)
		else $error("relay energised without power");
	a_relay_trip_a: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(relay_fn == acrts_pkg::RLY_NO_TRIP_A && power_ok) |=>
		relay_coil_out == $past(hit_a))
		else $error("trip A relay mismatch");
	a_trip_zero_off: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		trip_a == 8'h00 |=> !trip_a_reached_out)
		else $error("disabled trip point reported");
	a_duty_local_idle: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(!remote_sel && !awh_active) |-> !pulse)
		else $error("duty timer outside remote");
	a_duty_em_idle: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		(starter == acrts_pkg::STARTER_ELECTROMECH && !awh_active)
		|-> !pulse)
		else $error("duty timer with electromechanical starter");
	a_awh_override: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		awh_active |-> t_on == awh_sec && t_off == awh_sec)
		else $error("closing timer not overridden");
	a_motor_off_phase: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_off_phase |=> !open_motor_out && !close_motor_out)
		else $error("motor runs in off phase");
	a_point30_zero: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		status_index_in == acrts_pkg::IREG_STANDARD |=>
		!status_word_out[14] && status_word_out[15] == $past(unit_alarm))
		else $error("standard word alarm bits wrong");
	a_model_reserved: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		status_index_in == acrts_pkg::IREG_MODEL |=>
		status_word_out[15:5] == 11'h000)
		else $error("reserved model bits set");
endmodule
